// ===== logic/adc_setup_ctrl.sv
/*
 * Setup command decoder, scan start selection and internal reference
 * wake-up and shutdown control for the converter.
 * Assumes a serial host on SCLK, chip select and data in, sampling on the
 * rising edge, most significant bit first, and a converter core that
 * answers each scan start with a one-cycle scan done pulse.
 */
module adc_setup_ctrl
	import adc_setup_pkg::*;
#(
	parameter int CONV_CLK_DIV = CONV_CLK_DIV_DEFAULT
) (
	// System clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Serial link
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic DIN,
	// Start pin and converter core
	input wire logic CONVERT_START_PIN_N,
	input wire logic SCAN_DONE,
	// Setup state and scan controls
	output logic [1:0] CLK_MODE,
	output logic [1:0] REF_MODE,
	output logic [1:0] PAIR_CFG,
	output logic EXT_CONV_CLK,
	output logic SAMPLE_BY_START_PIN,
	output logic SAMPLE_BY_SCLK,
	output logic START_PIN_IS_INPUT,
	output logic REF_PIN_IS_INPUT,
	output logic ADC_EXT_REFERENCE,
	output logic REF_ON,
	output logic SCAN_GO,
	output logic SCAN_BUSY,
	output logic SCAN_TEMP
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_q1, rst_n;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// ----------------------------------------------------------------
	// Link domain: byte receiver
	// ----------------------------------------------------------------
	// Only the first byte of a frame is a command; later bytes belong to
	// registers outside this block. SCLK stops between frames, so the bit
	// counter is cleared by the frame's own chip select.
	logic link_clr_n;
	logic [2:0] bit_cnt, next_bit_cnt;
	logic [6:0] shift, next_shift;
	logic frame_full, next_frame_full;
	logic [7:0] rx_byte, next_rx_byte;
	logic rx_tgl, next_rx_tgl;
	logic edge_tgl;

	assign link_clr_n = rst_n && !CS_N;

	always_comb begin
		next_shift = {shift[5:0], DIN};
		next_bit_cnt = bit_cnt + 3'h1;
		next_frame_full = frame_full;
		next_rx_byte = rx_byte;
		next_rx_tgl = rx_tgl;
		if (frame_full) begin
			next_shift = shift;
			next_bit_cnt = bit_cnt;
		end else if (bit_cnt == 3'(BYTE_BITS - 1)) begin
			next_rx_byte = {shift, DIN};
			next_rx_tgl = !rx_tgl;
			next_frame_full = 1'b1;
		end
	end

	always_ff @(posedge SCLK or negedge link_clr_n) begin
		if (!link_clr_n) begin
			bit_cnt <= 3'h0;
			shift <= 7'h00;
			frame_full <= 1'b0;
		end else begin
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			frame_full <= next_frame_full;
		end
	end

	// The byte stays put for a whole frame, far longer than the crossing.
	always_ff @(posedge SCLK or negedge rst_n) begin
		if (!rst_n) begin
			rx_byte <= 8'h00;
			rx_tgl <= 1'b0;
			edge_tgl <= 1'b0;
		end else begin
			rx_byte <= next_rx_byte;
			rx_tgl <= next_rx_tgl;
			edge_tgl <= !edge_tgl;
		end
	end

	// ----------------------------------------------------------------
	// Crossings into the system domain
	// ----------------------------------------------------------------
	logic byte_rise, byte_fall, sclk_rise, sclk_fall, start_fall;

	edge_sync #(.INIT(1'b0)) u_byte_sync (
		.clk(MCLK),
		.rst_n(rst_n),
		.din(rx_tgl),
		.level(),
		.rise(byte_rise),
		.fall(byte_fall)
	);

	edge_sync #(.INIT(1'b0)) u_sclk_sync (
		.clk(MCLK),
		.rst_n(rst_n),
		.din(edge_tgl),
		.level(),
		.rise(sclk_rise),
		.fall(sclk_fall)
	);

	edge_sync #(.INIT(1'b1)) u_start_sync (
		.clk(MCLK),
		.rst_n(rst_n),
		.din(CONVERT_START_PIN_N),
		.level(),
		.rise(),
		.fall(start_fall)
	);

	// ----------------------------------------------------------------
	// Command decode and setup register
	// ----------------------------------------------------------------
	logic byte_evt;
	logic [7:0] setup, next_setup;
	logic conv_write, pin_start, scan_req;

	assign byte_evt = byte_rise || byte_fall;

	always_comb begin
		next_setup = setup;
		if (byte_evt && rx_byte[PREFIX_MSB:PREFIX_LSB] == SETUP_PREFIX) begin
			next_setup = rx_byte;
		end
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			setup <= SETUP_RESET;
		end else begin
			setup <= next_setup;
		end
	end

	assign conv_write = byte_evt && rx_byte[CONV_SELECT_BIT];
	assign pin_start = start_fall && !setup[CLK_MODE_LSB + 1];
	assign scan_req = (conv_write && setup[CLK_MODE_LSB + 1]) || pin_start;

	// ----------------------------------------------------------------
	// Conversion clock tick
	// ----------------------------------------------------------------
	logic [7:0] div_cnt, next_div_cnt;
	logic int_tick, next_int_tick;

	always_comb begin
		next_div_cnt = div_cnt + 8'h01;
		next_int_tick = 1'b0;
		if (div_cnt == 8'(CONV_CLK_DIV - 1)) begin
			next_div_cnt = 8'h00;
			next_int_tick = 1'b1;
		end
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 8'h00;
			int_tick <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			int_tick <= next_int_tick;
		end
	end

	// ----------------------------------------------------------------
	// Scan sequencer with reference wake-up
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {IDLE, WAKE, RUN} scan_state_e;

	scan_state_e state, next_state;
	logic [1:0] act_clk, next_act_clk, act_ref, next_act_ref;
	logic act_temp, next_act_temp;
	logic [WAIT_BITS-1:0] wait_cnt, next_wait_cnt;
	logic ref_on, next_ref_on, go, next_go;
	logic tick, want_ref, new_temp;
	logic [1:0] new_ref;

	// External clock mode counts every second rising serial clock edge.
	assign tick = (act_clk == CLK_EXT_SERIAL) ? sclk_rise : int_tick;
	assign new_ref = setup[REF_MODE_LSB +: 2];
	assign new_temp = conv_write ? rx_byte[TEMP_REQ_BIT] : act_temp;
	// External codes leave the reference off for inputs.
	assign want_ref = new_temp || !new_ref[0];

	always_comb begin
		next_state = state;
		next_act_clk = act_clk;
		next_act_ref = act_ref;
		next_act_temp = act_temp;
		next_wait_cnt = wait_cnt;
		next_ref_on = ref_on;
		next_go = 1'b0;
		if (conv_write && state == IDLE) begin
			next_act_temp = rx_byte[TEMP_REQ_BIT];
		end
		unique case (state)
			IDLE: begin
				if (scan_req) begin
					next_act_clk = setup[CLK_MODE_LSB +: 2];
					next_act_ref = new_ref;
					next_act_temp = new_temp;
					if (want_ref) begin
						next_wait_cnt = new_temp ? REF_WAKE_TEMP_CYCLES : REF_WAKE_AIN_CYCLES;
						next_ref_on = 1'b1;
						next_state = WAKE;
					end else begin
						next_go = 1'b1;
						next_state = RUN;
					end
				end
			end
			WAKE: begin
				if (tick) begin
					next_wait_cnt = wait_cnt - 8'h01;
					if (wait_cnt == 8'h01) begin
						next_go = 1'b1;
						next_state = RUN;
					end
				end
			end
			RUN: begin
				if (SCAN_DONE) begin
					next_ref_on = 1'b0;
					next_state = IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= IDLE;
			act_clk <= SETUP_RESET[CLK_MODE_LSB +: 2];
			act_ref <= SETUP_RESET[REF_MODE_LSB +: 2];
			act_temp <= 1'b0;
			wait_cnt <= '0;
			ref_on <= 1'b0;
			go <= 1'b0;
		end else begin
			state <= next_state;
			act_clk <= next_act_clk;
			act_ref <= next_act_ref;
			act_temp <= next_act_temp;
			wait_cnt <= next_wait_cnt;
			ref_on <= next_ref_on;
			go <= next_go;
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	// Outputs lag their sources by one cycle so that every port is a flop.
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			CLK_MODE <= SETUP_RESET[CLK_MODE_LSB +: 2];
			REF_MODE <= SETUP_RESET[REF_MODE_LSB +: 2];
			PAIR_CFG <= SETUP_RESET[PAIR_CFG_LSB +: 2];
			EXT_CONV_CLK <= 1'b0;
			SAMPLE_BY_START_PIN <= 1'b0;
			SAMPLE_BY_SCLK <= 1'b0;
			START_PIN_IS_INPUT <= 1'b0;
			REF_PIN_IS_INPUT <= 1'b0;
			ADC_EXT_REFERENCE <= 1'b0;
			REF_ON <= 1'b0;
			SCAN_GO <= 1'b0;
			SCAN_BUSY <= 1'b0;
			SCAN_TEMP <= 1'b0;
		end else begin
			CLK_MODE <= act_clk;
			REF_MODE <= act_ref;
			PAIR_CFG <= setup[PAIR_CFG_LSB +: 2];
			EXT_CONV_CLK <= (act_clk == CLK_EXT_SERIAL);
			SAMPLE_BY_START_PIN <= (act_clk == CLK_INT_PIN_SAMPLE);
			SAMPLE_BY_SCLK <= (act_clk == CLK_EXT_SERIAL);
			START_PIN_IS_INPUT <= act_clk[1];
			REF_PIN_IS_INPUT <= !act_ref[0];
			ADC_EXT_REFERENCE <= act_ref[0];
			REF_ON <= ref_on;
			SCAN_GO <= go;
			SCAN_BUSY <= (state != IDLE);
			SCAN_TEMP <= act_temp;
		end
	end

endmodule

// ===== shared/adc_setup_pkg.sv
/*
 * Constants for the converter setup and reference control block: command
 * byte layout, setup field positions, reset value, mode codes and the
 * reference wake-up delays.
 * Assumes a serial host that sends commands most significant bit first.
 */
// Overview of operation
// - A first byte with bit 7 low and bit 6 high is a write to the setup register.
// - The upper clock-mode bit, setup bit 5, comes up as one after reset.
// - Clock code 00 is internal clock with start pin, code 10 internal with the pin as input.
// - Clock code 01 runs the internal clock while the host times sampling on the start pin.
// - Clock code 11 clocks conversion from the serial clock, host keeps it at 3.6 MHz or less.
// - Reference code 10 is the default and its internal reference shuts off after the scan.
// - Codes 00 and 10 wait 218 conversion clocks when the reference was off, then shut it.
// - A temperature scan always wakes the internal reference and waits 244 clocks.
// - Codes 01 and 11 leave the internal reference off for analog-input conversions.
// - Setup bits 1:0 select the unipolar or bipolar pair register for differential use.
// - Reference codes 00 and 10 make the shared reference pin an analog input.
// - Clock codes 1x start a scan on a conversion write, codes 0x on a low start pulse.
package adc_setup_pkg;

	// ----------------------------------------------------------------
	// Command byte layout
	// ----------------------------------------------------------------
	localparam int BYTE_BITS = 8;
	localparam int PREFIX_MSB = 7;
	localparam int PREFIX_LSB = 6;
	localparam logic [1:0] SETUP_PREFIX = 2'h1;
	localparam int CONV_SELECT_BIT = 7;
	localparam int TEMP_REQ_BIT = 0;

	// ----------------------------------------------------------------
	// Setup register fields and reset value
	// ----------------------------------------------------------------
	localparam int CLK_MODE_LSB = 4;
	localparam int REF_MODE_LSB = 2;
	localparam int PAIR_CFG_LSB = 0;
	localparam logic [7:0] SETUP_RESET = 8'h28;

	localparam logic [1:0] CLK_INT_PIN_START = 2'h0;
	localparam logic [1:0] CLK_INT_PIN_SAMPLE = 2'h1;
	localparam logic [1:0] CLK_INT_AUTO = 2'h2;
	localparam logic [1:0] CLK_EXT_SERIAL = 2'h3;

	localparam logic [1:0] REF_INT_ALL = 2'h0;
	localparam logic [1:0] REF_EXT_SINGLE = 2'h1;
	localparam logic [1:0] REF_INT_ADC = 2'h2;
	localparam logic [1:0] REF_EXT_DIFF = 2'h3;

	// ----------------------------------------------------------------
	// Wake-up counts in conversion clock cycles; divider in system clock cycles
	// ----------------------------------------------------------------
	localparam int WAIT_BITS = 8;
	localparam logic [7:0] REF_WAKE_AIN_CYCLES = 8'(218);
	localparam logic [7:0] REF_WAKE_TEMP_CYCLES = 8'(244);
	localparam int CONV_CLK_DIV_DEFAULT = 4;

endpackage

// ===== logic/edge_sync.sv
/*
 * Three-stage synchroniser with an accepted level and change pulses.
 * Assumes the input is slow against clk; a change counts once the second
 * and third stages agree.
 */
module edge_sync
	import adc_setup_pkg::*;
#(
	parameter logic INIT = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw input and accepted view
	input wire logic din,
	output logic level,
	output logic rise,
	output logic fall
);

	logic s1, s2, s3;
	logic next_level, next_rise, next_fall;

	always_comb begin
		next_level = level;
		next_rise = 1'b0;
		next_fall = 1'b0;
		if (s2 == s3 && s3 != level) begin
			next_level = s3;
			next_rise = s3;
			next_fall = !s3;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			level <= INIT;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
			rise <= next_rise;
			fall <= next_fall;
		end
	end

endmodule

// ===== dv/adc_setup_ctrl_chk.sv
/* Checker for the setup and reference controller.
   Assumes it is bound to adc_setup_ctrl and sees its ports only. */
module adc_setup_ctrl_chk
	import adc_setup_pkg::*;
#(
	parameter int CONV_CLK_DIV = CONV_CLK_DIV_DEFAULT
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Watched outputs and done input
	input wire logic SCAN_DONE,
	input wire logic [1:0] CLK_MODE,
	input wire logic [1:0] REF_MODE,
	input wire logic EXT_CONV_CLK,
	input wire logic SAMPLE_BY_START_PIN,
	input wire logic SAMPLE_BY_SCLK,
	input wire logic START_PIN_IS_INPUT,
	input wire logic REF_PIN_IS_INPUT,
	input wire logic ADC_EXT_REFERENCE,
	input wire logic REF_ON,
	input wire logic SCAN_GO,
	input wire logic SCAN_BUSY,
	input wire logic SCAN_TEMP
);
	// ----------
	// Properties
	// ----------
	int t_cnt;
	int next_t_cnt;
	int lim;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	// Cycles since the reference woke; a slack of three covers the clock divider phase.
	always_comb begin
		next_t_cnt = REF_ON ? t_cnt + 1 : 0;
		lim = (SCAN_TEMP ? int'(REF_WAKE_TEMP_CYCLES) : int'(REF_WAKE_AIN_CYCLES)) * CONV_CLK_DIV;
	end
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			t_cnt <= 0;
		end else begin
			t_cnt <= next_t_cnt;
		end
	end
	AST_GO_ONE: assert property (SCAN_GO |=> !SCAN_GO)
		else $error("start pulse too long");
	AST_MODE_HOLD: assert property (SCAN_BUSY && $past(SCAN_BUSY) |->
		$stable(CLK_MODE) && $stable(REF_MODE)) else $error("modes moved in scan");
	AST_PIN_INPUT: assert property (SCAN_BUSY |-> START_PIN_IS_INPUT == CLK_MODE[1])
		else $error("start pin role wrong");
	AST_PIN_SAMPLE: assert property (SCAN_BUSY |->
		SAMPLE_BY_START_PIN == (CLK_MODE == 2'h1)) else $error("pin sampling wrong");
	AST_EXT_CLK: assert property (SCAN_BUSY |-> EXT_CONV_CLK == (CLK_MODE == 2'h3)
		&& SAMPLE_BY_SCLK == EXT_CONV_CLK) else $error("external clock wrong");
	AST_REF_PIN: assert property (SCAN_BUSY |-> REF_PIN_IS_INPUT != REF_MODE[0]
		&& ADC_EXT_REFERENCE == REF_MODE[0]) else $error("reference pin role wrong");
	AST_NO_INT_REF: assert property (SCAN_BUSY && REF_MODE[0] && !SCAN_TEMP |-> !REF_ON)
		else $error("reference on in external mode");
	AST_REF_READY: assert property (SCAN_GO && (!REF_MODE[0] || SCAN_TEMP) |-> REF_ON)
		else $error("start without reference");
	AST_WAKE_WAIT: assert property (SCAN_GO && REF_ON && CLK_MODE != 2'h3 |->
		t_cnt >= lim - 3 && t_cnt <= lim + 3) else $error("wake delay wrong");
	AST_SHUTDOWN: assert property (SCAN_DONE && SCAN_BUSY |-> ##2 !REF_ON && !SCAN_BUSY)
		else $error("reference not shut after scan");
	AST_COV_TEMP: cover property (SCAN_GO && SCAN_TEMP);
	AST_COV_AIN_REF: cover property (SCAN_GO && REF_ON && !SCAN_TEMP);
	AST_COV_NO_REF: cover property (SCAN_GO && !REF_ON);
endmodule

bind adc_setup_ctrl adc_setup_ctrl_chk #(.CONV_CLK_DIV(CONV_CLK_DIV)) adc_setup_ctrl_chk_i (
	.MCLK(MCLK), .RST_N(RST_N), .SCAN_DONE(SCAN_DONE), .CLK_MODE(CLK_MODE),
	.REF_MODE(REF_MODE), .EXT_CONV_CLK(EXT_CONV_CLK), .SAMPLE_BY_START_PIN(SAMPLE_BY_START_PIN),
	.SAMPLE_BY_SCLK(SAMPLE_BY_SCLK), .START_PIN_IS_INPUT(START_PIN_IS_INPUT),
	.REF_PIN_IS_INPUT(REF_PIN_IS_INPUT), .ADC_EXT_REFERENCE(ADC_EXT_REFERENCE),
	.REF_ON(REF_ON), .SCAN_GO(SCAN_GO), .SCAN_BUSY(SCAN_BUSY), .SCAN_TEMP(SCAN_TEMP)
);

// ===== dv/spi_host.sv
/* Serial host model sending one command byte per frame.
   Assumes the device samples data on the rising serial clock. */
module spi_host (
	// Serial link
	output logic sclk,
	output logic cs_n,
	output logic din
);
	timeunit 1ns;
	timeprecision 100ps;
	// -----
	// Frame
	// -----
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b1;
	end
	task automatic xfer(input logic [7:0] b, input int half);
		#(2 * half);
		cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			din = b[i];
			#half sclk = 1'b1;
			#half sclk = 1'b0;
		end
		// The clock stands still and the released line must not look valid.
		cs_n = 1'b1;
		din = ~din;
	endtask
endmodule

// ===== dv/tb.sv
/* Testbench for the setup and reference controller.
   Assumes the checker is bound in and the host model drives the link. */
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic MCLK, RST_N, SCLK, CS_N, DIN, CONVERT_START_PIN_N, SCAN_DONE;
	logic [1:0] CLK_MODE, REF_MODE, PAIR_CFG;
	logic EXT_CONV_CLK, SAMPLE_BY_START_PIN, SAMPLE_BY_SCLK, START_PIN_IS_INPUT;
	logic REF_PIN_IS_INPUT, ADC_EXT_REFERENCE, REF_ON, SCAN_GO, SCAN_BUSY, SCAN_TEMP;
	int failures, num_checks, woke;
	adc_setup_ctrl #(.CONV_CLK_DIV(1)) adc_setup_ctrl_i (
		.MCLK(MCLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN),
		.CONVERT_START_PIN_N(CONVERT_START_PIN_N), .SCAN_DONE(SCAN_DONE),
		.CLK_MODE(CLK_MODE), .REF_MODE(REF_MODE), .PAIR_CFG(PAIR_CFG),
		.EXT_CONV_CLK(EXT_CONV_CLK), .SAMPLE_BY_START_PIN(SAMPLE_BY_START_PIN),
		.SAMPLE_BY_SCLK(SAMPLE_BY_SCLK), .START_PIN_IS_INPUT(START_PIN_IS_INPUT),
		.REF_PIN_IS_INPUT(REF_PIN_IS_INPUT), .ADC_EXT_REFERENCE(ADC_EXT_REFERENCE),
		.REF_ON(REF_ON), .SCAN_GO(SCAN_GO), .SCAN_BUSY(SCAN_BUSY), .SCAN_TEMP(SCAN_TEMP)
	);
	spi_host spi_host_i (.sclk(SCLK), .cs_n(CS_N), .din(DIN));
	// -------
	// Helpers
	// -------
	initial begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end
	task automatic step(input int n);
		repeat (n) @(posedge MCLK);
		#2;
	endtask
	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic setup(input logic [7:0] b);
		spi_host_i.xfer(b, 40);
		step(10);
	endtask
	// Counts the cycles with the reference up before the start pulse; with a
	// divider of one every system cycle is one conversion clock.
	task automatic wait_go;
		int n;
		n = 0;
		woke = 0;
		while (SCAN_GO !== 1'b1 && n < 1000) begin
			if (REF_ON === 1'b1) begin
				woke++;
			end
			step(1);
			n++;
		end
		if (n == 1000) begin
			failures++;
			final_report();
		end
	endtask
	task automatic pin_pulse;
		CONVERT_START_PIN_N = 1'b0;
		step(4);
		CONVERT_START_PIN_N = 1'b1;
	endtask
	task automatic finish_scan;
		SCAN_DONE = 1'b1;
		step(1);
		SCAN_DONE = 1'b0;
		step(3);
		chk("ref_on", 8'(REF_ON), 8'h0);
		chk("busy", 8'(SCAN_BUSY), 8'h0);
	endtask
	// ---------
	// Scenarios
	// ---------
	task automatic t_decode;
		chk("clk_mode", 8'(CLK_MODE), 8'h2);
		chk("ref_mode", 8'(REF_MODE), 8'h2);
		setup(8'h3F);
		chk("pair", 8'(PAIR_CFG), 8'h0);
		setup(8'h6B);
		chk("pair", 8'(PAIR_CFG), 8'h3);
	endtask
	task automatic t_ain_ref;
		fork
			spi_host_i.xfer(8'h80, 40);
			wait_go();
		join
		chk("ref_on", 8'(REF_ON), 8'h1);
		chk("wake", 8'(woke), adc_setup_pkg::REF_WAKE_AIN_CYCLES);
		chk("pin_in", 8'(START_PIN_IS_INPUT), 8'h1);
		chk("ref_pin", 8'(REF_PIN_IS_INPUT), 8'h1);
		setup(8'h75);
		chk("pair", 8'(PAIR_CFG), 8'h1);
		chk("clk_mode", 8'(CLK_MODE), 8'h2);
		finish_scan();
	endtask
	task automatic t_ext_clk;
		fork
			spi_host_i.xfer(8'h80, 140);
			wait_go();
		join
		chk("ext_clk", 8'(EXT_CONV_CLK), 8'h1);
		chk("smp_sclk", 8'(SAMPLE_BY_SCLK), 8'h1);
		chk("clk_mode", 8'(CLK_MODE), 8'h3);
		chk("ref_pin", 8'(REF_PIN_IS_INPUT), 8'h0);
		chk("ext_ref", 8'(ADC_EXT_REFERENCE), 8'h1);
		chk("ref_on", 8'(REF_ON), 8'h0);
		chk("wake", 8'(woke), 8'h0);
		finish_scan();
	endtask
	task automatic t_temp;
		setup(8'h64);
		fork
			spi_host_i.xfer(8'h81, 40);
			wait_go();
		join
		chk("temp", 8'(SCAN_TEMP), 8'h1);
		chk("ref_on", 8'(REF_ON), 8'h1);
		chk("wake", 8'(woke), adc_setup_pkg::REF_WAKE_TEMP_CYCLES);
		finish_scan();
	endtask
	task automatic t_pin;
		for (int m = 0; m < 2; m++) begin
			setup(8'h44 | 8'(m << 4));
			spi_host_i.xfer(8'h80, 40);
			step(10);
			chk("busy", 8'(SCAN_BUSY), 8'h0);
			fork
				pin_pulse();
				wait_go();
			join
			chk("smp_pin", 8'(SAMPLE_BY_START_PIN), 8'(m));
			chk("pin_in", 8'(START_PIN_IS_INPUT), 8'h0);
			finish_scan();
		end
	endtask
	initial begin
		RST_N = 1'b0;
		CONVERT_START_PIN_N = 1'b1;
		SCAN_DONE = 1'b0;
		step(10);
		RST_N = 1'b1;
		step(4);
		t_decode();
		t_ain_ref();
		t_ext_clk();
		t_temp();
		t_pin();
		final_report();
	end
endmodule
